// ### design/t1_alarm_params.svh
// offsets, field positions and timing counts of the alarm status block
`ifndef T1_ALARM_PARAMS_SVH
`define T1_ALARM_PARAMS_SVH

// register byte addresses
`define ADDR_CONTROL        8'h00
`define ADDR_LOOPUP_PAT     8'h04
`define ADDR_LOOPDOWN_PAT   8'h08
`define ADDR_SPARE_PAT      8'h0C
`define ADDR_LEVEL_INFO     8'h40
`define ADDR_STATUS_ONE_A   8'h20
`define ADDR_INFO_THREE_B   8'hB0

// control register fields
`define CTL_ROUTE_BIT       6
`define CTL_FALLBACK_BIT    7
`define CTL_RESET           8'h00
`define PAT_RESET           8'h00

// status one framer a fields
`define ST_LOOPUP_BIT       7
`define ST_LOOPDOWN_BIT     6
`define ST_TXCLK_BIT        5
`define ST_SPARE_BIT        4
`define ST_BLUE_BIT         3
`define ST_YELLOW_BIT       2
`define ST_CARRIER_BIT      1
`define ST_SYNC_BIT         0

// info three framer b fields, level field
`define INFO_RXCLK_BIT      4
`define INFO_AIS_BIT        0
`define LEVEL_HI_BIT        7
`define LEVEL_LO_BIT        6

// timing
`define SYS_CLK_MHZ         200
`define RX_CLK_LOSS_NS      2000
`define RX_CLK_LOSS_CYCLES  ((`RX_CLK_LOSS_NS * `SYS_CLK_MHZ + 999) / 1000)
`define TX_CLK_LOSS_NS      5200
`define TX_CLK_LOSS_CYCLES  ((`TX_CLK_LOSS_NS * `SYS_CLK_MHZ + 999) / 1000)
`define BLUE_WINDOW_US      3000
`define BLUE_WINDOW_CYCLES  (`BLUE_WINDOW_US * `SYS_CLK_MHZ)
`define BLUE_SET_MAX_ZEROS  3'd5
`define RED_SET_ZEROS       8'd192
`define RED_CLR_WINDOW      7'd112
`define RED_CLR_ONES        4'd14
`define CODE_QUAL_BITS      48

`endif

// ### design/t1_alarm_pkg.sv
// types shared by the alarm status block
package t1_alarm_pkg;
  typedef logic [1:0] rx_level_type;
  typedef enum logic [1:0] {
    RED_CLEAR = 2'b00,
    RED_SET   = 2'b01,
    RED_QUAL  = 2'b10
  } red_state_type;
endpackage

// ### design/clock_loss_watch.sv
// watchdog flagging a pin clock with no transition for too long
`timescale 1ns/1ps
module clock_loss_watch #(
  parameter int LIMIT = 400
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // watched pin and result
  input  wire logic clock_pin,
  output logic      lost
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic          sync1;
  logic          sync2;
  logic          sync3;
  logic [CW-1:0] idle_count;
  wire           edge_seen = sync2 ^ sync3;
  wire           at_limit  = (idle_count == LIM);

  // two flops into the system domain, third for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= clock_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // count idle cycles, saturate at the limit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_count <= '0;
      lost       <= 1'b0;
    end else begin
      idle_count <= edge_seen ? '0 : (at_limit ? idle_count
                                               : idle_count + 1'b1);
      lost       <= at_limit && !edge_seen;
    end
  end
endmodule // clock_loss_watch

// ### design/code_pattern_match.sv
// detector for a repeating in-band code held in a pattern register
`timescale 1ns/1ps
module code_pattern_match #(
  parameter int WIDTH     = 8,
  parameter int QUAL_BITS = 48
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // received bit stream, code pattern and match result
  input  wire logic             bit_strobe,
  input  wire logic             bit_in,
  input  wire logic [WIDTH-1:0] pattern,
  output logic                  match
);
  localparam int QW = $clog2(QUAL_BITS + 1);
  localparam logic [QW-1:0] QMAX = QW'(QUAL_BITS);

  logic [WIDTH-1:0]   history;
  logic [QW-1:0]      run;
  logic [WIDTH-1:0]   rot_hit;
  wire  [2*WIDTH-1:0] doubled   = {pattern, pattern};
  wire  [WIDTH-1:0]   next_hist = {history[WIDTH-2:0], bit_in};
  wire                hit       = |rot_hit;

  // the code may arrive in any phase: compare every rotation
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_rot
      assign rot_hit[i] = (next_hist == doubled[i +: WIDTH]);
    end
  endgenerate

  // count consecutive matching bits, flag once qualified
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      history <= '0;
      run     <= '0;
      match   <= 1'b0;
    end else if (bit_strobe) begin
      history <= next_hist;
      run     <= !hit ? '0 : ((run == QMAX) ? run : run + 1'b1);
      match   <= hit && (run >= QMAX - 1'b1);
    end
  end
endmodule // code_pattern_match

// ### design/t1_receive_alarm_status.sv
// receive alarm status and information registers on a wishbone slave
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "t1_alarm_params.svh"

// Function
// [RQ1] framer b receive clock idle 2 us flags
// [RQ2] ais-ci flag follows detected pattern
// [RQ3] ais-ci flag needs blue alarm set
// [RQ4] software rechecks dropped ais-ci after 1.5 s
// [RQ5] two-bit receive level code
// [RQ6] unassigned bits carry no meaning
// [RQ7] loop-up code seen sets bit 7
// [RQ8] transmit clock idle 5.2 us sets bit 5
// [RQ9] transmit loss drives pin when routed
// [RQ10] transmit loss selects master clock when enabled
// [RQ11] spare code seen sets bit 4
// [RQ12] unframed all ones sets blue alarm
// [RQ13] yellow alarm sets bit 2
// [RQ14] red alarm sets carrier loss bit 1
// [RQ15] bit 0 held while out of sync
// [RQ16] red: 192 zeros; clear 14 ones/112
// [RQ17] blue: <=5 zeros per 3 ms window
// [RQ18] loop-down code seen sets bit 6
module t1_receive_alarm_status #(
  parameter int BLUE_WINDOW = `BLUE_WINDOW_CYCLES,
  parameter int CODE_QUAL   = `CODE_QUAL_BITS
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [7:0]  WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_W,
  output logic      [31:0] WB_DAT_R,
  output logic             WB_ACK,
  // line pins
  input  wire logic        RX_POSITIVE_DATA_A,
  input  wire logic        RX_NEGATIVE_DATA_A,
  input  wire logic        RX_CLOCK_A,
  input  wire logic        FRAMER_B_RX_CLOCK_IN,
  input  wire logic        FRAMER_A_TX_CLOCK_IN,
  // framer and line interface indications
  input  wire logic        FRAME_SYNC_OK,
  input  wire logic        YELLOW_DETECT,
  input  wire logic        AIS_CI_PATTERN,
  input  wire logic [1:0]  RX_LEVEL,
  // alarm outputs
  output logic             SYNC_OR_TXCLK_LOSS_PIN,
  output logic             TX_CLOCK_FALLBACK
);
  localparam int BW = $clog2(BLUE_WINDOW + 1);
  localparam logic [BW-1:0] BLUE_LAST = BW'(BLUE_WINDOW - 1);

  // registers
  logic [7:0]                 control;
  logic [7:0]                 loopup_pattern_reg;
  logic [7:0]                 loopdown_pattern_reg;
  logic [7:0]                 spare_pattern_reg;
  t1_alarm_pkg::rx_level_type rx_level;
  logic                       frame_sync_loss;
  logic                       yellow_alarm;
  logic                       ais_ci_detect;
  // line sampling
  logic [2:0]                 pin_s1;
  logic [2:0]                 pin_s2;
  logic                       clk_s3;
  // red and blue detectors
  t1_alarm_pkg::red_state_type red_state;
  logic [7:0]                 zero_run;
  logic [6:0]                 clr_bits;
  logic [3:0]                 clr_ones;
  logic [BW-1:0]              blue_timer;
  logic [2:0]                 blue_zeros;
  logic                       blue_alarm;
  // detector outputs
  logic                       receive_clock_lost;
  logic                       transmit_clock_lost;
  logic                       loopup_code_seen;
  logic                       loopdown_code_seen;
  logic                       spare_code_seen;

  // synchronise data and bit clock pins
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      clk_s3 <= 1'b0;
    end else begin
      pin_s1 <= {RX_CLOCK_A, RX_NEGATIVE_DATA_A, RX_POSITIVE_DATA_A};
      pin_s2 <= pin_s1;
      clk_s3 <= pin_s2[2];
    end
  end

  // a mark on either rail is a one, sampled at bit clock rise
  wire bit_strobe = pin_s2[2] && !clk_s3;
  wire rx_one     = pin_s2[0] | pin_s2[1];
  wire is_zero    = bit_strobe && !rx_one;

  // [RQ1] receive clock watchdog
  clock_loss_watch #(.LIMIT(`RX_CLK_LOSS_CYCLES)) u_rx_watch (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .clock_pin (FRAMER_B_RX_CLOCK_IN),
    .lost      (receive_clock_lost)
  );

  // [RQ8] transmit clock watchdog
  clock_loss_watch #(.LIMIT(`TX_CLK_LOSS_CYCLES)) u_tx_watch (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .clock_pin (FRAMER_A_TX_CLOCK_IN),
    .lost      (transmit_clock_lost)
  );

  // [RQ7] loop-up code detector
  code_pattern_match #(.WIDTH(8), .QUAL_BITS(CODE_QUAL)) u_loopup (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .bit_strobe (bit_strobe),
    .bit_in     (rx_one),
    .pattern    (loopup_pattern_reg),
    .match      (loopup_code_seen)
  );

  // [RQ18] loop-down code detector
  code_pattern_match #(.WIDTH(8), .QUAL_BITS(CODE_QUAL)) u_loopdown (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .bit_strobe (bit_strobe),
    .bit_in     (rx_one),
    .pattern    (loopdown_pattern_reg),
    .match      (loopdown_code_seen)
  );

  // [RQ11] spare code detector
  code_pattern_match #(.WIDTH(8), .QUAL_BITS(CODE_QUAL)) u_spare (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .bit_strobe (bit_strobe),
    .bit_in     (rx_one),
    .pattern    (spare_pattern_reg),
    .match      (spare_code_seen)
  );

  // red alarm qualifier terms
  wire red_hit_zeros = is_zero && (zero_run == `RED_SET_ZEROS - 8'd1);
  wire clr_done      = bit_strobe && rx_one &&
                       (clr_ones == `RED_CLR_ONES - 4'd1);
  wire clr_expire    = bit_strobe && (clr_bits == `RED_CLR_WINDOW);

  // [RQ16] consecutive zero run, saturating
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      zero_run <= 8'h00;
    end else if (bit_strobe) begin
      zero_run <= rx_one ? 8'h00 : ((zero_run == `RED_SET_ZEROS) ? zero_run
                                                  : zero_run + 8'd1);
    end
  end

  // [RQ16] red alarm set and one-density clearing window
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      red_state <= t1_alarm_pkg::RED_CLEAR;
      clr_bits  <= 7'h00;
      clr_ones  <= 4'h0;
    end else begin
      case (red_state)
        t1_alarm_pkg::RED_CLEAR: begin
          if (red_hit_zeros) begin
            red_state <= t1_alarm_pkg::RED_SET;
          end
        end
        t1_alarm_pkg::RED_SET: begin
          if (bit_strobe && rx_one) begin
            red_state <= t1_alarm_pkg::RED_QUAL;
            clr_bits  <= 7'h01;
            clr_ones  <= 4'h1;
          end
        end
        t1_alarm_pkg::RED_QUAL: begin
          // window closes first: a one at bit 113 must not clear
          if (clr_expire) begin
            red_state <= t1_alarm_pkg::RED_SET;
          end else if (clr_done) begin
            red_state <= t1_alarm_pkg::RED_CLEAR;
          end else if (bit_strobe) begin
            clr_bits <= clr_bits + 7'd1;
            clr_ones <= clr_ones + {3'h0, rx_one};
          end
        end
        default: begin
          red_state <= t1_alarm_pkg::RED_CLEAR;
        end
      endcase
    end
  end

  // [RQ14] carrier loss while red is set or being qualified
  wire framer_carrier_loss = (red_state != t1_alarm_pkg::RED_CLEAR);

  // [RQ17] blue alarm window timing and decision
  wire blue_end = (blue_timer == BLUE_LAST);
  // closing window count, one bit wider so a full count cannot wrap
  wire [3:0] blue_total = {1'b0, blue_zeros} + {3'h0, is_zero};
  wire       blue_ok    = (blue_total <= {1'b0, `BLUE_SET_MAX_ZEROS});
  wire       next_blue  = blue_end ? blue_ok : blue_alarm;
  // [RQ12] few zeros over the window means unframed all ones
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      blue_timer <= '0;
      blue_zeros <= 3'h0;
      blue_alarm <= 1'b0;
    end else if (blue_end) begin
      blue_timer <= '0;
      blue_zeros <= 3'h0;
      blue_alarm <= next_blue;
    end else begin
      blue_timer <= blue_timer + 1'b1;
      blue_zeros <= (is_zero && blue_zeros != 3'h7) ? blue_zeros + 3'd1
                                                    : blue_zeros;
    end
  end

  // framer indications and qualified ais-ci
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      frame_sync_loss <= 1'b1;
      yellow_alarm    <= 1'b0;
      ais_ci_detect   <= 1'b0;
      rx_level        <= 2'b00;
    end else begin
      // [RQ15] out of sync
      frame_sync_loss <= !FRAME_SYNC_OK;
      // [RQ13] yellow alarm
      yellow_alarm    <= YELLOW_DETECT;
      // [RQ2] [RQ3] gated by blue as it stands after this edge
      ais_ci_detect   <= AIS_CI_PATTERN && next_blue;
      // [RQ5] receive level code
      rx_level        <= RX_LEVEL;
    end
  end

  // [RQ9] [RQ10] transmit clock loss consequences
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      SYNC_OR_TXCLK_LOSS_PIN <= 1'b0;
      TX_CLOCK_FALLBACK      <= 1'b0;
    end else begin
      SYNC_OR_TXCLK_LOSS_PIN <= frame_sync_loss ||
        (transmit_clock_lost && control[`CTL_ROUTE_BIT]);
      TX_CLOCK_FALLBACK      <= transmit_clock_lost &&
        control[`CTL_FALLBACK_BIT];
    end
  end

  // status and information images; [RQ6] unassigned bits read zero
  wire [7:0] status_one_a = {loopup_code_seen, loopdown_code_seen,
                             transmit_clock_lost, spare_code_seen,
                             blue_alarm, yellow_alarm,
                             framer_carrier_loss, frame_sync_loss};
  wire [7:0] info_three_b = {3'h0, receive_clock_lost, 3'h0,
                             ais_ci_detect};
  wire [7:0] level_info   = {rx_level, 6'h00};

  // address decode
  wire bus_req  = WB_CYC && WB_STB && !WB_ACK;
  wire wr_lane0 = bus_req && WB_WE && WB_SEL[0];
  wire sel_ctl  = (WB_ADR == `ADDR_CONTROL);
  wire sel_up   = (WB_ADR == `ADDR_LOOPUP_PAT);
  wire sel_dn   = (WB_ADR == `ADDR_LOOPDOWN_PAT);
  wire sel_sp   = (WB_ADR == `ADDR_SPARE_PAT);
  wire [7:0] read_byte =
    sel_ctl                          ? control :
    sel_up                           ? loopup_pattern_reg :
    sel_dn                           ? loopdown_pattern_reg :
    sel_sp                           ? spare_pattern_reg :
    (WB_ADR == `ADDR_STATUS_ONE_A)   ? status_one_a :
    (WB_ADR == `ADDR_INFO_THREE_B)   ? info_three_b :
    (WB_ADR == `ADDR_LEVEL_INFO)     ? level_info : 8'h00;

  // writable registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      control              <= `CTL_RESET;
      loopup_pattern_reg   <= `PAT_RESET;
      loopdown_pattern_reg <= `PAT_RESET;
      spare_pattern_reg    <= `PAT_RESET;
    end else if (wr_lane0) begin
      if (sel_ctl) begin
        control <= WB_DAT_W[7:0];
      end else if (sel_up) begin
        loopup_pattern_reg <= WB_DAT_W[7:0];
      end else if (sel_dn) begin
        loopdown_pattern_reg <= WB_DAT_W[7:0];
      end else if (sel_sp) begin
        spare_pattern_reg <= WB_DAT_W[7:0];
      end
    end
  end

  // one-cycle acknowledge with registered read data
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      WB_ACK   <= 1'b0;
      WB_DAT_R <= 32'h0000_0000;
    end else begin
      WB_ACK   <= bus_req;
      WB_DAT_R <= bus_req ? {24'h00_0000, read_byte} : 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_run_done;
    red_hit_zeros;
  endsequence

  a_ais_needs_blue: assert property (ais_ci_detect |-> blue_alarm) // [RQ3]
    else $error("ais-ci set without blue alarm");
  a_ais_follows_in: assert property ( // [RQ2]
    AIS_CI_PATTERN |=> (ais_ci_detect == blue_alarm))
    else $error("ais-ci flag missed the pattern");
  a_pin_routed: assert property ( // [RQ9]
    transmit_clock_lost && control[`CTL_ROUTE_BIT] |=> SYNC_OR_TXCLK_LOSS_PIN)
    else $error("loss pin not driven on transmit loss");
  a_fallback_sel: assert property ( // [RQ10]
    transmit_clock_lost && control[`CTL_FALLBACK_BIT] |=> TX_CLOCK_FALLBACK)
    else $error("no master clock fallback");
  a_red_declared: assert property ( // [RQ16]
    s_run_done and (red_state == t1_alarm_pkg::RED_CLEAR)
    |=> framer_carrier_loss && status_one_a[`ST_CARRIER_BIT])
    else $error("red alarm not declared after zero run");
  a_blue_decides: assert property ( // [RQ17]
    blue_end && blue_total > {1'b0, `BLUE_SET_MAX_ZEROS}
    |=> !blue_alarm)
    else $error("blue alarm kept with many zeros");
  a_sync_loss: assert property ( // [RQ15]
    !FRAME_SYNC_OK ##1 !FRAME_SYNC_OK |=> status_one_a[`ST_SYNC_BIT][*1])
    else $error("sync loss bit not held");
  a_ack_single: assert property (WB_ACK |=> !WB_ACK)
    else $error("acknowledge longer than one cycle");
  a_level_read: assert property ( // [RQ5]
    $past(RX_LEVEL, 2) == $past(RX_LEVEL) |-> level_info[7:6] == $past(RX_LEVEL))
    else $error("level code wrong");
endmodule // t1_receive_alarm_status

// ### verification/t1_line_model.sv
// line-side partner: receive rails, bit clock and framer clock pins
`timescale 1ns/1ps
module t1_line_model (
  // clock
  input  wire logic clk,
  // free-running pin clock controls
  input  wire logic rxb_run,
  input  wire logic txa_run,
  // line pins
  output logic      rx_pos,
  output logic      rx_neg,
  output logic      rx_clk,
  output logic      rxb_clk,
  output logic      txa_clk
);
  logic       pol;
  logic [2:0] div;

  // quiet line, all clocks low
  initial begin
    {rx_pos, rx_neg, rx_clk, rxb_clk, txa_clk, pol, div} = '0;
  end

  // framer pin clocks toggle every 8 cycles while running
  always @(posedge clk) begin
    div <= div + 3'h1;
    if (div == 3'h0 && rxb_run) rxb_clk <= ~rxb_clk;
    if (div == 3'h0 && txa_run) txa_clk <= ~txa_clk;
  end

  // bipolar marks, zeros leave both rails low
  task automatic send_bit(input logic b);
    @(posedge clk);
    rx_pos <= b & pol;
    rx_neg <= b & ~pol;
    pol = pol ^ b;
    repeat (2) @(posedge clk);
    rx_clk <= 1'b1;
    repeat (4) @(posedge clk);
    rx_clk <= 1'b0;
    repeat (2) @(posedge clk);
    // rails stop holding the bit once the clock has fallen
    {rx_pos, rx_neg} <= ~{rx_pos, rx_neg};
  endtask
endmodule // t1_line_model

// ### verification/tb_t1_receive_alarm_status.sv
// self-checking bench for the receive alarm status registers
`timescale 1ns/1ps
`include "t1_alarm_params.svh"
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_t1_receive_alarm_status;
  logic        clk_sys  = 1'b0;
  logic        rst_n    = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] dat_w    = 32'h00000000;
  logic        sync_ok  = 1'b0;
  logic        yellow   = 1'b0;
  logic        ais      = 1'b0;
  logic [1:0]  level    = 2'h0;
  logic        rxb_run  = 1'b1;
  logic        txa_run  = 1'b1;
  logic [31:0] dat_r;
  logic        ack;
  logic        loss_pin;
  logic        fallback;
  logic        rx_pos;
  logic        rx_neg;
  logic        rx_clk;
  logic        rxb_clk;
  logic        txa_clk;
  int          n_errors  = 0;
  int          tests_run = 0;
  logic [7:0]  pats [0:2] = '{8'hF0, 8'hCC, 8'hAA};
  logic [7:0]  hits [0:2] = '{8'h80, 8'h40, 8'h10};
  logic [7:0]  ctls [0:3] = '{8'h00, 8'h40, 8'h80, 8'hC0};

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  t1_receive_alarm_status #(.BLUE_WINDOW(200), .CODE_QUAL(16))
    u_t1_receive_alarm_status (
    .CLK_SYS(clk_sys), .RST_N(rst_n),
    .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr),
    .WB_SEL(sel), .WB_DAT_W(dat_w), .WB_DAT_R(dat_r), .WB_ACK(ack),
    .RX_POSITIVE_DATA_A(rx_pos), .RX_NEGATIVE_DATA_A(rx_neg),
    .RX_CLOCK_A(rx_clk), .FRAMER_B_RX_CLOCK_IN(rxb_clk),
    .FRAMER_A_TX_CLOCK_IN(txa_clk), .FRAME_SYNC_OK(sync_ok),
    .YELLOW_DETECT(yellow), .AIS_CI_PATTERN(ais), .RX_LEVEL(level),
    .SYNC_OR_TXCLK_LOSS_PIN(loss_pin), .TX_CLOCK_FALLBACK(fallback));

  t1_line_model u_t1_line_model (
    .clk(clk_sys), .rxb_run(rxb_run), .txa_run(txa_run),
    .rx_pos(rx_pos), .rx_neg(rx_neg), .rx_clk(rx_clk),
    .rxb_clk(rxb_clk), .txa_clk(txa_clk));

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [7:0] d, input logic [3:0] s,
                         output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= s;
    dat_w <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    `CHECK(ack, 1'b1)
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    logic [31:0] rd;
    wb_xfer(1'b1, a, d, s, rd);
  endtask

  // read and compare the masked low byte, upper bits must be zero
  task automatic chk(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [31:0] rd;
    wb_xfer(1'b0, a, 8'h00, 4'hF, rd);
    `CHECK(rd & {24'hFFFFFF, m}, {24'h000000, e})
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // n line bits cycling through a byte, msb first
  task automatic send(input int n, input logic [7:0] p);
    for (int i = 0; i < n; i++) u_t1_line_model.send_bit(p[7 - i % 8]);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog against a hung handshake or bit stream
  initial begin
    idle(60000);
    n_errors++;
    close_out();
  end

  initial begin
    idle(4);
    rst_n <= 1'b1;
    // control reset value, lane-off write, unmapped place
    chk(`ADDR_CONTROL, 8'hFF, 8'h00);
    wr(`ADDR_CONTROL, 8'hC0, 4'h0);
    chk(`ADDR_CONTROL, 8'hFF, 8'h00);
    wr(8'h7C, 8'hFF, 4'hF);
    chk(8'h7C, 8'hFF, 8'h00);
    chk(`ADDR_INFO_THREE_B, 8'hEE, 8'h00);
    // every level code
    for (int i = 0; i < 4; i++) begin
      level <= i[1:0];
      idle(2);
      chk(`ADDR_LEVEL_INFO, 8'hC0, {i[1:0], 6'h00});
    end
    // sync loss and yellow indications
    yellow <= 1'b1;
    chk(`ADDR_STATUS_ONE_A, 8'h05, 8'h05);
    `CHECK(loss_pin, 1'b1)
    yellow  <= 1'b0;
    sync_ok <= 1'b1;
    ais     <= 1'b1;
    chk(`ADDR_STATUS_ONE_A, 8'h05, 8'h00);
    `CHECK(loss_pin, 1'b0)
    // red alarm at exactly the 192nd zero
    send(191, 8'h00);
    chk(`ADDR_STATUS_ONE_A, 8'h0A, 8'h00);
    send(1, 8'h00);
    chk(`ADDR_STATUS_ONE_A, 8'h02, 8'h02);
    chk(`ADDR_INFO_THREE_B, 8'h01, 8'h00);
    // 13 ones do not clear, the 14th within 112 bits does
    for (int i = 0; i < 13; i++) send(8, 8'h80);
    chk(`ADDR_STATUS_ONE_A, 8'h02, 8'h02);
    send(1, 8'h80);
    chk(`ADDR_STATUS_ONE_A, 8'h02, 8'h00);
    // red again; the 14th one lands at bit 113, past the window
    send(192, 8'h00);
    for (int i = 0; i < 13; i++) begin
      send(1, 8'h80);
      send((i < 12) ? 8 : 3, 8'h00);
    end
    send(1, 8'h80);
    chk(`ADDR_STATUS_ONE_A, 8'h02, 8'h02);
    send(14, 8'hFF);
    chk(`ADDR_STATUS_ONE_A, 8'h02, 8'h00);
    // unframed all ones raises blue, which qualifies ais-ci
    send(60, 8'hFF);
    chk(`ADDR_STATUS_ONE_A, 8'h08, 8'h08);
    chk(`ADDR_INFO_THREE_B, 8'h01, 8'h01);
    ais <= 1'b0;
    idle(2);
    chk(`ADDR_INFO_THREE_B, 8'h01, 8'h00);
    // software waits before trusting a dropped flag
    idle(100);
    chk(`ADDR_INFO_THREE_B, 8'h01, 8'h00);
    ais <= 1'b1;
    send(60, 8'hB6);
    chk(`ADDR_STATUS_ONE_A, 8'h08, 8'h00);
    chk(`ADDR_INFO_THREE_B, 8'h01, 8'h00);
    // each code detector answers only to its own pattern
    wr(`ADDR_LOOPUP_PAT, pats[0], 4'h1);
    wr(`ADDR_LOOPDOWN_PAT, pats[1], 4'h1);
    wr(`ADDR_SPARE_PAT, pats[2], 4'h1);
    for (int i = 0; i < 3; i++) begin
      send(40, pats[i]);
      chk(`ADDR_STATUS_ONE_A, 8'hD0, hits[i]);
    end
    // framer b receive clock loss around 400 idle cycles
    rxb_run <= 1'b0;
    idle(380);
    chk(`ADDR_INFO_THREE_B, 8'h10, 8'h00);
    idle(40);
    chk(`ADDR_INFO_THREE_B, 8'h10, 8'h10);
    rxb_run <= 1'b1;
    idle(40);
    chk(`ADDR_INFO_THREE_B, 8'h10, 8'h00);
    // transmit clock loss around 1040 idle cycles, then routing
    txa_run <= 1'b0;
    idle(1000);
    chk(`ADDR_STATUS_ONE_A, 8'h20, 8'h00);
    idle(60);
    chk(`ADDR_STATUS_ONE_A, 8'h20, 8'h20);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CONTROL, ctls[i], 4'h1);
      idle(2);
      `CHECK(loss_pin, ctls[i][6])
      `CHECK(fallback, ctls[i][7])
    end
    chk(`ADDR_CONTROL, 8'hFF, 8'hC0);
    txa_run <= 1'b1;
    idle(40);
    chk(`ADDR_STATUS_ONE_A, 8'h20, 8'h00);
    `CHECK(fallback, 1'b0)
    `CHECK(loss_pin, 1'b0)
    close_out();
  end
endmodule // tb_t1_receive_alarm_status
